// ### rtl/bli2c_map.svh
`ifndef BLI2C_MAP_SVH
`define BLI2C_MAP_SVH
// Register byte offsets
`define BLI2C_OFF_CON       8'hd8
`define BLI2C_OFF_DAT       8'hd9
`define BLI2C_OFF_CFG       8'hc8
`define BLI2C_ADDR_W        8
// Control register bit positions
`define BLI2C_B_RECEIVED_BIT        7
`define BLI2C_B_ATN         6
`define BLI2C_B_BIT_READY_FLAG        5
`define BLI2C_B_ARL         4
`define BLI2C_B_STR         3
`define BLI2C_B_STP         2
`define BLI2C_B_MASTER      1
`define BLI2C_B_CXA         7
`define BLI2C_B_IDLE        6
`define BLI2C_B_CDR         5
`define BLI2C_B_CLEAR_ARBITRATION_LOST        4
`define BLI2C_B_CLEAR_START_SEEN        3
`define BLI2C_B_CLEAR_STOP_SEEN        2
`define BLI2C_B_SEND_REPEATED_START        1
`define BLI2C_B_SEND_STOP        0
// Configuration register
`define BLI2C_B_SLAVE_ENABLE      7
`define BLI2C_B_MASTER_REQUEST      6
`define BLI2C_B_TIMEOUT_TIMER_RUN       4
`define BLI2C_B_CT_HI       1
`define BLI2C_B_CT_LO       0
`define BLI2C_CFG_RESET     8'h00
`define BLI2C_CFG_WMASK     8'hd3
// Minimum SCL high time before start/stop edge, in ns
`define BLI2C_MIN_TIME_NS   600
`define BLI2C_CLK_PERIOD_NS 5
`define BLI2C_CNT_W         10
// Edges from our own SDA release until the synchroniser shows it
`define BLI2C_SETTLE_CYC    2'h3
`endif

// ### rtl/bli2c_pkg.sv
package bli2c_pkg;
    typedef enum logic [1:0] {
        BLI2C_TX_DATA  = 2'b00,
        BLI2C_TX_RSTART = 2'b01,
        BLI2C_TX_STOP  = 2'b10
    } bli2c_txkind_t;
    typedef logic [31:0] bli2c_word_t;
endpackage

// ### rtl/bli2c_sync.sv
`timescale 1ns/1ps
// ==========================================
// Two-stage synchroniser, one per bit
module bli2c_sync #(
    parameter int WIDTH = 2
) (
    input  wire logic             ref_clk,
    input  wire logic             rstn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            always_ff @(posedge ref_clk or negedge rstn) begin
                if (!rstn) begin
                    meta_reg[g] <= 1'b1;
                    sync_out[g] <= 1'b1;
                end else begin
                    meta_reg[g] <= async_in[g];
                    sync_out[g] <= meta_reg[g];
                end
            end
        end
    endgenerate
endmodule // bli2c_sync

// ### rtl/bli2c_core.sv
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`include "bli2c_map.svh"
// Notes on behaviour
// - Stretch continues while other flags set
// - Arbitration loss clears transmit-active
// - Sent one, SDA low at rise
// - Sent one, foreign repeated start seen
// - Repeated start beaten by early SCL low
// - Stop blocked by foreign zero
// - Start flag only master or active slave
// - Stop flag only master or active slave
// - Master granted when requested and bus free
// - Master dropped on loss or release stop
// - Transmit-active set/cleared by register accesses
// - SDA driven and loss flagged only transmitting
// - Idle ignores bus until next start
// - Data-ready cleared by command or data access
// - Clear bits act on one only
// - SCL held low while any flag set and interface active
// - Repeated start: release, wait, pull low
// - Stop: pull low, wait, release
// - Slave enable; all zero disables interface
// - Data-ready and received bit at SCL rise
// - Transmit bit applied only while SCL low
module bli2c_core
    import bli2c_pkg::*;
#(
    parameter int MIN_TIME_NS = `BLI2C_MIN_TIME_NS
) (
    input  wire logic                      ref_clk,
    input  wire logic                      rstn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [`BLI2C_ADDR_W-1:0]  paddr,
    input  wire bli2c_pkg::bli2c_word_t    pwdata,
    output bli2c_pkg::bli2c_word_t         prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic                      scl_in,
    output logic                           scl_out,
    output logic                           scl_oe_n,
    input  wire logic                      sda_in,
    output logic                           sda_out,
    output logic                           sda_oe_n,
    input  wire logic                      bus_timeout,
    output logic                           attention_flag
);
    import bli2c_pkg::*;

    localparam int MIN_CYC_I = (MIN_TIME_NS + `BLI2C_CLK_PERIOD_NS - 1) / `BLI2C_CLK_PERIOD_NS;
    localparam logic [`BLI2C_CNT_W-1:0] MIN_CYC = (MIN_CYC_I < 1) ? `BLI2C_CNT_W'(1)
                                                                  : `BLI2C_CNT_W'(MIN_CYC_I);

    // ==========================================
    // Pin synchronisers and edges
    logic [1:0] pins_sync;
    logic       scl_s;
    logic       sda_s;
    logic       scl_d_reg;
    logic       sda_d_reg;
    bli2c_sync #(.WIDTH(2)) u_sync (
        .ref_clk  (ref_clk),
        .rstn     (rstn),
        .async_in ({scl_in, sda_in}),
        .sync_out (pins_sync)
    );
    assign scl_s = pins_sync[1];
    assign sda_s = pins_sync[0];

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    assign scl_rise  = scl_s & ~scl_d_reg;
    assign scl_fall  = ~scl_s & scl_d_reg;
    assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    assign stop_det  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

    // ==========================================
    // APB decode
    logic acc;
    logic wr_con;
    logic wr_dat;
    logic rd_dat;
    logic wr_cfg;
    logic mapped;
    assign acc    = psel & penable & pready;
    assign mapped = (paddr == `BLI2C_OFF_CON) | (paddr == `BLI2C_OFF_DAT) | (paddr == `BLI2C_OFF_CFG);
    assign wr_con = acc & pwrite & (paddr == `BLI2C_OFF_CON);
    assign wr_dat = acc & pwrite & (paddr == `BLI2C_OFF_DAT);
    assign rd_dat = acc & ~pwrite & (paddr == `BLI2C_OFF_DAT);
    assign wr_cfg = acc & pwrite & (paddr == `BLI2C_OFF_CFG);

    logic cmd_cxa;
    logic cmd_idle;
    logic cmd_cdr;
    logic cmd_clear_arbitration_lost;
    logic cmd_clear_start_seen;
    logic cmd_clear_stop_seen;
    logic cmd_send_repeated_start;
    logic cmd_send_stop;
    assign cmd_cxa  = wr_con & pwdata[`BLI2C_B_CXA];
    assign cmd_idle = wr_con & pwdata[`BLI2C_B_IDLE];
    assign cmd_cdr  = wr_con & pwdata[`BLI2C_B_CDR];
    assign cmd_clear_arbitration_lost = wr_con & pwdata[`BLI2C_B_CLEAR_ARBITRATION_LOST];
    assign cmd_clear_start_seen = wr_con & pwdata[`BLI2C_B_CLEAR_START_SEEN];
    assign cmd_clear_stop_seen = wr_con & pwdata[`BLI2C_B_CLEAR_STOP_SEEN];
    assign cmd_send_repeated_start = wr_con & pwdata[`BLI2C_B_SEND_REPEATED_START];
    assign cmd_send_stop = wr_con & pwdata[`BLI2C_B_SEND_STOP];

    // ==========================================
    // Configuration register
    logic [7:0] cfg_reg;
    logic       slave_enable;
    logic       master_request;
    logic       enabled;
    assign slave_enable   = cfg_reg[`BLI2C_B_SLAVE_ENABLE];
    assign master_request = cfg_reg[`BLI2C_B_MASTER_REQUEST];
    assign enabled        = slave_enable | master_request;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cfg_reg <= `BLI2C_CFG_RESET;
        end else if (wr_cfg) begin
            cfg_reg <= pwdata[7:0] & `BLI2C_CFG_WMASK;
        end else if (bus_timeout) begin
            cfg_reg[`BLI2C_B_SLAVE_ENABLE] <= 1'b0;
        end
    end

    // ==========================================
    // Bus state: busy, idle slave, master
    logic bus_busy_reg;
    logic idle_reg;
    logic master_reg;
    logic release_armed_reg;
    logic arl_set;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            bus_busy_reg <= 1'b0;
        end else if (bus_timeout | stop_det) begin
            bus_busy_reg <= 1'b0;
        end else if (start_det) begin
            bus_busy_reg <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            idle_reg <= 1'b0;
        end else if (cmd_idle) begin
            idle_reg <= 1'b1;
        end else if (start_det) begin
            idle_reg <= 1'b0;
        end
    end

    // Master taken when bus free; release armed by request cleared then stop command
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            release_armed_reg <= 1'b0;
        end else if (!master_reg) begin
            release_armed_reg <= 1'b0;
        end else if (cmd_send_stop & ~master_request) begin
            release_armed_reg <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            master_reg <= 1'b0;
        end else if (arl_set) begin
            master_reg <= 1'b0;
        end else if (release_armed_reg & stop_det) begin
            master_reg <= 1'b0;
        end else if (master_request & ~bus_busy_reg & ~master_reg & ~start_det) begin
            master_reg <= 1'b1;
        end
    end

    logic active;
    assign active = enabled & (master_reg | ~idle_reg);

    // ==========================================
    // Transmit state
    logic          xact_reg;
    logic          tx_bit_reg;
    bli2c_txkind_t tx_kind_reg;
    logic          sda_drive_reg;
    logic [`BLI2C_CNT_W-1:0] min_cnt_reg;
    logic          cond_done_reg;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            tx_bit_reg  <= 1'b1;
            tx_kind_reg <= BLI2C_TX_DATA;
        end else if (cmd_send_repeated_start) begin
            tx_bit_reg  <= 1'b1;
            tx_kind_reg <= BLI2C_TX_RSTART;
        end else if (cmd_send_stop) begin
            tx_bit_reg  <= 1'b0;
            tx_kind_reg <= BLI2C_TX_STOP;
        end else if (wr_dat) begin
            tx_bit_reg  <= pwdata[`BLI2C_B_RECEIVED_BIT];
            tx_kind_reg <= BLI2C_TX_DATA;
        end else if (scl_fall) begin
            tx_kind_reg <= BLI2C_TX_DATA;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            xact_reg <= 1'b0;
        end else if (arl_set) begin
            xact_reg <= 1'b0;
        end else if (wr_dat | cmd_send_repeated_start | cmd_send_stop) begin
            xact_reg <= 1'b1;
        end else if (rd_dat | cmd_cxa) begin
            xact_reg <= 1'b0;
        end
    end

    // Minimum high time counter for condition generation
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            min_cnt_reg <= '0;
        end else if (!scl_s) begin
            min_cnt_reg <= '0;
        end else if (min_cnt_reg != MIN_CYC) begin
            min_cnt_reg <= min_cnt_reg + `BLI2C_CNT_W'(1);
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cond_done_reg <= 1'b0;
        end else if (!scl_s) begin
            cond_done_reg <= 1'b0;
        end else if (min_cnt_reg == MIN_CYC && tx_kind_reg != BLI2C_TX_DATA) begin
            cond_done_reg <= 1'b1;
        end
    end

    // Data changes only while SCL low; condition edge flips SDA after min time
    logic sda_level;
    always_comb begin
        sda_level = sda_drive_reg;
        if (!scl_s) begin
            sda_level = ~tx_bit_reg;
        end else if (cond_done_reg) begin
            sda_level = (tx_kind_reg == BLI2C_TX_RSTART);
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sda_drive_reg <= 1'b0;
        end else begin
            sda_drive_reg <= sda_level & xact_reg & active & ~arl_set;
        end
    end

    // ==========================================
    // Arbitration loss detection (only while transmitting)
    // Without this age a released SDA still reads low for a few edges: false stop loss
    logic [1:0] rel_age_reg;
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rel_age_reg <= '0;
        end else if (sda_drive_reg | ~scl_s) begin
            rel_age_reg <= '0;
        end else if (rel_age_reg != `BLI2C_SETTLE_CYC) begin
            rel_age_reg <= rel_age_reg + 2'h1;
        end
    end

    logic arl_case1;
    logic arl_case2;
    logic arl_case3;
    logic arl_case4;
    logic want_high;
    assign want_high = tx_bit_reg & ~sda_drive_reg;
    assign arl_case1 = scl_rise & want_high & ~sda_s & ~cond_done_reg;
    assign arl_case2 = start_det & want_high & (tx_kind_reg == BLI2C_TX_DATA);
    assign arl_case3 = master_reg & (tx_kind_reg == BLI2C_TX_RSTART) & scl_fall
                     & scl_d_reg & ~cond_done_reg & sda_d_reg;
    assign arl_case4 = master_reg & (tx_kind_reg == BLI2C_TX_STOP) & cond_done_reg & ~sda_drive_reg
                     & (rel_age_reg == `BLI2C_SETTLE_CYC) & ~sda_s & scl_s & scl_d_reg & ~sda_d_reg;
    assign arl_set   = xact_reg & active & (arl_case1 | arl_case2 | arl_case3 | arl_case4);

    // ==========================================
    // Status flags; set wins over clear
    logic bit_ready_flag_reg;
    logic arl_reg;
    logic str_reg;
    logic stp_reg;
    logic received_bit_reg;
    logic any_flag;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            received_bit_reg <= 1'b0;
        end else if (scl_rise) begin
            received_bit_reg <= sda_s;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            bit_ready_flag_reg <= 1'b0;
        end else if (scl_rise & active) begin
            bit_ready_flag_reg <= 1'b1;
        end else if (cmd_cdr | wr_dat | rd_dat) begin
            bit_ready_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            arl_reg <= 1'b0;
        end else if (arl_set) begin
            arl_reg <= 1'b1;
        end else if (cmd_clear_arbitration_lost) begin
            arl_reg <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            str_reg <= 1'b0;
        end else if (start_det & enabled & (master_reg | ~idle_reg)) begin
            str_reg <= 1'b1;
        end else if (cmd_clear_start_seen) begin
            str_reg <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            stp_reg <= 1'b0;
        end else if (stop_det & enabled & (master_reg | ~idle_reg)) begin
            stp_reg <= 1'b1;
        end else if (cmd_clear_stop_seen) begin
            stp_reg <= 1'b0;
        end
    end

    assign any_flag = bit_ready_flag_reg | arl_reg | str_reg | stp_reg;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            attention_flag <= 1'b0;
        end else begin
            attention_flag <= any_flag;
        end
    end

    // ==========================================
    // Pins: clock stretch and SDA drive, enables active low
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            scl_out  <= 1'b1;
            scl_oe_n <= 1'b1;
            sda_out  <= 1'b1;
            sda_oe_n <= 1'b1;
        end else begin
            scl_out  <= 1'b0;
            // Only holds an already low SCL; never pulls mid high phase
            scl_oe_n <= ~(active & any_flag & (~scl_s | ~scl_oe_n));
            sda_out  <= 1'b0;
            sda_oe_n <= ~sda_level | ~xact_reg | ~active | arl_set;
        end
    end

    // ==========================================
    // APB slave: zero wait states
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
            prdata  <= '0;
            if (psel & ~penable & ~pwrite) begin
                unique case (paddr)
                    `BLI2C_OFF_CON: prdata[7:0] <= {received_bit_reg, any_flag, bit_ready_flag_reg, arl_reg,
                                                    str_reg, stp_reg, master_reg, 1'b0};
                    `BLI2C_OFF_DAT: prdata[7:0] <= {received_bit_reg, 7'h00};
                    `BLI2C_OFF_CFG: prdata[7:0] <= cfg_reg;
                    default:        prdata      <= '0;
                endcase
            end
        end
    end
endmodule // bli2c_core

// ### verification/bli2c_core_sva.sv
`timescale 1ns/1ps
`include "bli2c_map.svh"
// ==========================================
// Port checker
module bli2c_core_sva (
    input wire logic                     ref_clk,
    input wire logic                     rstn,
    input wire logic                     psel,
    input wire logic                     penable,
    input wire logic                     pwrite,
    input wire logic [`BLI2C_ADDR_W-1:0] paddr,
    input wire bli2c_pkg::bli2c_word_t   pwdata,
    input wire bli2c_pkg::bli2c_word_t   prdata,
    input wire logic                     pready,
    input wire logic                     pslverr,
    input wire logic                     scl_in,
    input wire logic                     scl_oe_n,
    input wire logic                     sda_oe_n,
    input wire logic                     attention_flag
);
    import bli2c_pkg::*;
    logic tx_pos_reg;
    logic acc;
    logic mapped;
    assign acc    = psel && penable && pready;
    assign mapped = paddr == `BLI2C_OFF_CON || paddr == `BLI2C_OFF_DAT || paddr == `BLI2C_OFF_CFG;
    // Upper bound on transmit-active, seen from register traffic only
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn)
            tx_pos_reg <= 1'b0;
        else if (acc && pwrite && (paddr == `BLI2C_OFF_DAT || (paddr == `BLI2C_OFF_CON && |pwdata[1:0])))
            tx_pos_reg <= 1'b1;
        else if (acc && (paddr == `BLI2C_OFF_DAT || (paddr == `BLI2C_OFF_CON && pwdata[7])))
            tx_pos_reg <= 1'b0;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable && pready;
    endsequence
    AST_APB_ANSWER:
        assert property (s_setup |=> s_access) else $error("no answer after setup");
    AST_PREADY_PULSE:
        assert property (pready |-> psel && penable ##1 !pready) else $error("pready outside one access cycle");
    AST_SLVERR_MAP:
        assert property (pready |-> pslverr == !mapped) else $error("pslverr does not match address");
    AST_READ_UPPER_ZERO:
        assert property (pready && !pwrite |-> prdata[31:8] == 24'h00_0000) else $error("upper read bits set");
    AST_ATTN_SUM:
        assert property (acc && !pwrite && paddr == `BLI2C_OFF_CON |->
                         prdata[6] == |prdata[5:2] && attention_flag == prdata[6])
        else $error("attention bit differs from flags");
    AST_CFG_RESERVED:
        assert property (acc && !pwrite && paddr == `BLI2C_OFF_CFG |-> (prdata[7:0] & ~`BLI2C_CFG_WMASK) == 8'h00)
        else $error("reserved config bits read set");
    AST_SDA_TX_ONLY:
        assert property (!tx_pos_reg && !$past(tx_pos_reg) |-> sda_oe_n) else $error("sda pulled without transmit");
    AST_STRETCH_HOLD:
        assert property ((attention_flag && !scl_in) [*5] |-> !scl_oe_n) else $error("scl released with flags set");
endmodule // bli2c_core_sva

bind bli2c_core bli2c_core_sva chk_u (
    .ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl_in),
    .scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n), .attention_flag(attention_flag)
);

// ### verification/bli2c_bus_model.sv
`timescale 1ns/1ps
// ==========================================
// Foreign master on the bus, 64 ns bit clock
module bli2c_bus_model (
    input  wire logic scl_w,
    output logic      scl_drv,
    output logic      sda_drv
);
    localparam time HALF = 32;
    // Released lines float to the pull-up, so 1 means let go
    initial begin
        scl_drv = 1'b1;
        sda_drv = 1'b1;
    end
    // Calls start off the clock edge; SCL low and high phases are half a period each
    task automatic send_start();
        #(HALF / 2);
        sda_drv = 1'b0;
        #HALF;
        scl_drv = 1'b0;
    endtask
    // Data held past the falling edge until the next call moves it
    task automatic send_bit(input logic b);
        #(HALF / 2);
        sda_drv = b;
        #(HALF / 2);
        scl_drv = 1'b1;
        wait (scl_w === 1'b1);
        #HALF;
        scl_drv = 1'b0;
    endtask
    task automatic send_stop();
        #(HALF / 2);
        sda_drv = 1'b0;
        #(HALF / 2);
        scl_drv = 1'b1;
        wait (scl_w === 1'b1);
        #HALF;
        sda_drv = 1'b1;
        #HALF;
    endtask
endmodule // bli2c_bus_model

// ### verification/test_bit_level_i2c_interface.sv
`timescale 1ns/1ps
`include "bli2c_map.svh"
// ==========================================
// Bench top
module test_bit_level_i2c_interface;
    import bli2c_pkg::*;
    logic        ref_clk;
    logic        rstn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    bli2c_word_t pwdata;
    bli2c_word_t prdata;
    logic        pready;
    logic        pslverr;
    logic        scl_out;
    logic        scl_oe_n;
    logic        sda_out;
    logic        sda_oe_n;
    logic        bus_timeout;
    logic        attention_flag;
    logic        scl_drv;
    logic        sda_drv;
    logic        scl_w;
    logic        sda_w;
    int          miscompares;
    int          tests_run;
    int          cycles;
    // Wired-AND with pull-ups
    assign scl_w = scl_drv & (scl_oe_n | scl_out);
    assign sda_w = sda_drv & (sda_oe_n | sda_out);
    bli2c_core #(.MIN_TIME_NS(50)) dut_u (
        .ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl_w),
        .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda_w), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .bus_timeout(bus_timeout), .attention_flag(attention_flag)
    );
    bli2c_bus_model bus_u (.scl_w(scl_w), .scl_drv(scl_drv), .sda_drv(sda_drv));
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, {24'h00_0000, d}, q, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0000_0000, q, e);
        chk(q, exp);
        chk({31'h0000_0000, e}, {31'h0000_0000, exp_err});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            end_sim();
        end
    end
    initial begin
        miscompares = 0;
        tests_run   = 0;
        cycles      = 0;
        rstn        = 1'b0;
        psel        = 1'b0;
        penable     = 1'b0;
        pwrite      = 1'b0;
        paddr       = 8'h00;
        pwdata      = 32'h0000_0000;
        bus_timeout = 1'b0;
        cyc(2);
        rstn <= 1'b1;
        rd(`BLI2C_OFF_CFG, 32'h0000_0000, 1'b0);
        rd(8'h10, 32'h0000_0000, 1'b1);
        $display("test registers done");
        wr(`BLI2C_OFF_CFG, 8'h80);
        wr(`BLI2C_OFF_CON, 8'h40);
        bus_u.send_start();
        cyc(10);
        rd(`BLI2C_OFF_CON, 32'h0000_0000, 1'b0);
        bus_u.send_bit(1'b1);
        cyc(10);
        chk({31'h0000_0000, attention_flag}, 32'h0000_0001);
        rd(`BLI2C_OFF_CON, 32'h0000_00e0, 1'b0);
        chk({31'h0000_0000, scl_oe_n}, 32'h0000_0000);
        rd(`BLI2C_OFF_DAT, 32'h0000_0080, 1'b0);
        cyc(10);
        chk({31'h0000_0000, scl_oe_n}, 32'h0000_0001);
        rd(`BLI2C_OFF_CON, 32'h0000_0080, 1'b0);
        bus_u.send_bit(1'b0);
        cyc(10);
        rd(`BLI2C_OFF_CON, 32'h0000_0060, 1'b0);
        wr(`BLI2C_OFF_CON, 8'h20);
        rd(`BLI2C_OFF_CON, 32'h0000_0000, 1'b0);
        $display("test slave bits done");
        wr(`BLI2C_OFF_DAT, 8'h80);
        bus_u.send_bit(1'b0);
        cyc(10);
        rd(`BLI2C_OFF_CON, 32'h0000_0070, 1'b0);
        wr(`BLI2C_OFF_CON, 8'h20);
        cyc(2);
        chk({31'h0000_0000, scl_oe_n}, 32'h0000_0000);
        wr(`BLI2C_OFF_CON, 8'h10);
        rd(`BLI2C_OFF_CON, 32'h0000_0000, 1'b0);
        $display("test arbitration done");
        bus_u.send_stop();
        cyc(10);
        rd(`BLI2C_OFF_CON, 32'h0000_0064, 1'b0);
        wr(`BLI2C_OFF_CON, 8'h00);
        rd(`BLI2C_OFF_CON, 32'h0000_0064, 1'b0);
        wr(`BLI2C_OFF_CON, 8'h24);
        rd(`BLI2C_OFF_CON, 32'h0000_0000, 1'b0);
        $display("test stop flag done");
        wr(`BLI2C_OFF_CFG, 8'hc0);
        cyc(10);
        rd(`BLI2C_OFF_CON, 32'h0000_0002, 1'b0);
        wr(`BLI2C_OFF_CFG, 8'hff);
        rd(`BLI2C_OFF_CFG, 32'h0000_00d3, 1'b0);
        @(posedge ref_clk);
        bus_timeout <= 1'b1;
        @(posedge ref_clk);
        bus_timeout <= 1'b0;
        cyc(5);
        rd(`BLI2C_OFF_CFG, 32'h0000_0053, 1'b0);
        $display("test master and config done");
        bus_u.send_start();
        rd(`BLI2C_OFF_CON, 32'h0000_004a, 1'b0);
        wr(`BLI2C_OFF_CFG, 8'h80);
        wr(`BLI2C_OFF_CON, 8'h29);
        cyc(2);
        chk({31'h0000_0000, sda_oe_n}, 32'h0000_0000);
        chk({30'h0000_0000, scl_out, sda_out}, 32'h0000_0000);
        bus_u.send_stop();
        cyc(20);
        rd(`BLI2C_OFF_CON, 32'h0000_0064, 1'b0);
        $display("test master stop done");
        wr(`BLI2C_OFF_CON, 8'ha4);
        wr(`BLI2C_OFF_CFG, 8'hc0);
        bus_u.send_start();
        wr(`BLI2C_OFF_CON, 8'h2a);
        bus_u.send_bit(1'b1);
        cyc(10);
        rd(`BLI2C_OFF_CON, 32'h0000_00f0, 1'b0);
        $display("test repeated start done");
        end_sim();
    end
endmodule // test_bit_level_i2c_interface
